// ==== rtl/scs_pkg.sv ====
// Shared constants and types of the conversion sequencer
package scs_pkg;
   localparam int CODE_W = 16;
   // Timing figures in their own units, clock at 125 MHz
   localparam int CLK_MHZ = 125;
   localparam int WARP_KSPS = 570;
   localparam int NORMAL_KSPS = 500;
   localparam int GAP_US = 1000;
   // Cycles per conversion period, rounded down (shortest time)
   localparam int WARP_PERIOD_CYC = (CLK_MHZ * 1000) / WARP_KSPS;
   localparam int NORMAL_PERIOD_CYC = (CLK_MHZ * 1000) / NORMAL_KSPS;
   localparam int GAP_CYC = CLK_MHZ * GAP_US;
   // Switch-opening and grounding steps, one cycle each
   localparam int OPEN_CYC = 1;
   localparam int GROUND_CYC = 1;
   localparam logic [15:0] CODE_RESET = 16'h0000;
   localparam logic [15:0] CODE_MAX_SB = 16'hFFFF;
   localparam logic [15:0] CODE_MIN_SB = 16'h0000;
   localparam logic [15:0] MSB_ONLY = 16'h8000;
   localparam logic [4:0] BIT_LAST = 5'h00;
   localparam logic [4:0] BIT_FIRST = 5'h0F;

   // Speed/power modes
   typedef enum logic [1:0]
   {
      SCS_MODE_NORMAL = 2'b00,
      SCS_MODE_WARP = 2'b01,
      SCS_MODE_IMPULSE = 2'b10
   } scs_mode_t;

   // Sequencer states
   typedef enum logic [2:0]
   {
      SCS_ACQUIRE = 3'b000,
      SCS_OPEN = 3'b001,
      SCS_GROUND = 3'b010,
      SCS_TRIAL = 3'b011,
      SCS_LATCH = 3'b100
   } scs_state_t;
endpackage

// ==== rtl/scs_sequencer.sv ====
// Successive-approximation conversion sequencer, top level
module scs_sequencer
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Host controls, asynchronous pins
   input wire logic conversion_start_n,
   input wire logic coding_select,
   input wire logic warp_select,
   input wire logic impulse_select,
   // Analog front end status
   input wire logic comparator_high,
   input wire logic over_range,
   input wire logic under_range,
   // Analog switch controls
   output logic sample_switch_closed,
   output logic array_ground_switch,
   output logic dummy_ground_switch,
   output logic array_to_reference_ground,
   output logic [scs_pkg::CODE_W-1:0] dac_trial,
   output logic analog_power_up,
   // Result toward the read-out interface
   output logic busy,
   output logic [scs_pkg::CODE_W-1:0] output_code,
   output logic first_result_stale,
   output scs_pkg::scs_mode_t active_mode
);
   import scs_pkg::*;

   scs_state_t state;
   scs_state_t next_state;
   logic start_level;
   logic start_prev;
   logic [4:0] bit_idx;
   logic [15:0] trial;
   logic [15:0] next_trial;
   logic range_over;
   logic range_under;
   logic [20:0] gap_count;
   logic warp_stale;
   logic coding_level;
   logic warp_level;
   logic impulse_level;

   // Only the start pin is edge-sensitive; it is filtered like the level straps
   scs_sync u_start_sync
   (
      .clk(clk),
      .rst(rst),
      .async_in(conversion_start_n),
      .reset_level(1'b1),
      .level(start_level)
   );

   // Level straps filtered too; reset levels match their idle settings
   scs_sync u_coding_sync
   (
      .clk(clk),
      .rst(rst),
      .async_in(coding_select),
      .reset_level(1'b1),
      .level(coding_level)
   );

   scs_sync u_warp_sync
   (
      .clk(clk),
      .rst(rst),
      .async_in(warp_select),
      .reset_level(1'b0),
      .level(warp_level)
   );

   scs_sync u_impulse_sync
   (
      .clk(clk),
      .rst(rst),
      .async_in(impulse_select),
      .reset_level(1'b0),
      .level(impulse_level)
   );

   // Falling start edge while idle launches a conversion
   wire start_fall = start_prev & ~start_level;
   wire in_acquire = (state == SCS_ACQUIRE);
   wire launch = in_acquire & start_fall;
   wire last_bit = (bit_idx == BIT_LAST);
   // Mode straps read between conversions; a mid-conversion change waits
   wire sel_impulse = impulse_level & ~warp_level;
   wire sel_warp = warp_level;

   // Trial bit decision: keep when comparator says input above trial
   wire [15:0] bit_mask = 16'h0001 << bit_idx;
   wire [15:0] next_bit_mask = bit_mask >> 1;
   always_comb
   begin
      next_trial = trial;
      if (!comparator_high)
         next_trial = trial & ~bit_mask;
      if (!last_bit)
         next_trial = next_trial | next_bit_mask;
   end

   // Clamp and format the resolved code
   wire [15:0] sb_code = range_over ? CODE_MAX_SB :
                         range_under ? CODE_MIN_SB : next_trial;
   wire [15:0] fmt_code = coding_level ? sb_code : (sb_code ^ MSB_ONLY);

   // State sequence: open, ground, sixteen trials, latch
   always_comb
   begin
      case (state)
         SCS_ACQUIRE: next_state = launch ? SCS_OPEN : SCS_ACQUIRE;
         SCS_OPEN: next_state = SCS_GROUND;
         SCS_GROUND: next_state = SCS_TRIAL;
         SCS_TRIAL: next_state = last_bit ? SCS_LATCH : SCS_TRIAL;
         SCS_LATCH: next_state = SCS_ACQUIRE;
         default: next_state = SCS_ACQUIRE;
      endcase
   end

   // Switch drive decoded from state; opening precedes grounding
   assign sample_switch_closed = in_acquire;
   assign array_ground_switch = in_acquire;
   assign dummy_ground_switch = in_acquire;
   assign array_to_reference_ground = (state == SCS_GROUND) | (state == SCS_TRIAL);
   assign dac_trial = trial;
   // Impulse mode powers the analog core only while converting
   assign analog_power_up = (active_mode != SCS_MODE_IMPULSE) | ~in_acquire;
   assign first_result_stale = warp_stale & (active_mode == SCS_MODE_WARP);

   // Control state
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state <= SCS_ACQUIRE;
         start_prev <= 1'b1;
      end
      else
      begin
         state <= next_state;
         start_prev <= start_level;
      end
   end

   // Search register; one trial per clock, MSB first
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         trial <= CODE_RESET;
         bit_idx <= BIT_FIRST;
      end
      else if (state == SCS_GROUND)
      begin
         trial <= MSB_ONLY;
         bit_idx <= BIT_FIRST;
      end
      else if (state == SCS_TRIAL)
      begin
         trial <= next_trial;
         bit_idx <= bit_idx - 5'h01;
      end
   end

   // Range flags sampled once, in the ground step of this sample only
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         range_over <= 1'b0;
         range_under <= 1'b0;
      end
      else if (state == SCS_GROUND)
      begin
         range_over <= over_range;
         range_under <= under_range;
      end
   end

   // Result and busy; code updates in the cycle busy falls
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         output_code <= CODE_RESET;
         busy <= 1'b0;
      end
      else
      begin
         if (launch)
            busy <= 1'b1;
         else if (state == SCS_TRIAL && last_bit)
            busy <= 1'b0;
         if (state == SCS_TRIAL && last_bit)
            output_code <= fmt_code;
      end
   end

   // Mode captured only between conversions
   always_ff @(posedge clk)
   begin
      if (rst)
         active_mode <= SCS_MODE_NORMAL;
      else if (in_acquire && !launch)
         active_mode <= sel_impulse ? SCS_MODE_IMPULSE :
                        sel_warp ? SCS_MODE_WARP : SCS_MODE_NORMAL;
   end

   // Warp idle-gap watch so the host can drop a stale result
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         // Power-up counts as a long gap, so the first result is flagged
         gap_count <= 21'(GAP_CYC);
         warp_stale <= 1'b1;
      end
      else if (launch)
      begin
         gap_count <= '0;
         warp_stale <= (gap_count >= 21'(GAP_CYC));
      end
      else if (gap_count < 21'(GAP_CYC))
         gap_count <= gap_count + 21'h0_0001;
   end
endmodule // scs_sequencer

// ==== rtl/scs_sync.sv ====
// Three-stage input synchroniser with agreement filter
module scs_sync
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Asynchronous level in, filtered level out
   input wire logic async_in,
   input wire logic reset_level,
   output logic level
);
   logic s1;
   logic s2;
   logic s3;
   wire agree = (s2 == s3);

   // Stage chain; first stage feeds only the second
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s1 <= reset_level;
         s2 <= reset_level;
         s3 <= reset_level;
      end
      else
      begin
         s1 <= async_in;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Output follows only when two late stages agree
   always_ff @(posedge clk)
   begin
      if (rst)
         level <= reset_level;
      else if (agree)
         level <= s3;
   end
endmodule // scs_sync

// ==== testbench/scs_host.sv ====
// Host start pulses and ideal comparator
module scs_host
(
   // Clock
   input wire logic clk,
   // Bench request and held sample
   input wire logic start,
   input wire logic [15:0] sample,
   input wire logic [15:0] dac_trial,
   // Toward the sequencer
   output logic conversion_start_n,
   output logic comparator_high
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] low_cnt = 3'h0;
   // Low pulse outlasts the input filter
   always @(posedge clk) low_cnt <= start ? 3'h6 : low_cnt - {2'h0, low_cnt != 3'h0};
   assign conversion_start_n = low_cnt == 3'h0;
   // Keep a trial bit while the sample reaches it
   assign comparator_high = sample >= dac_trial;
endmodule // scs_host

// ==== testbench/scs_sequencer_tb.sv ====
// Self-checking bench of the conversion sequencer
module scs_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import scs_pkg::*;
   logic clk = 0;
   logic rst = 1;
   logic start = 0;
   logic coding_select = 1;
   logic warp_select = 0;
   logic impulse_select = 0;
   logic over_range = 0;
   logic under_range = 0;
   logic [15:0] sample = 16'h0000;
   logic conversion_start_n, comparator_high, sample_switch_closed, busy, analog_power_up;
   logic [CODE_W-1:0] dac_trial, output_code;
   logic first_result_stale;
   scs_mode_t active_mode;
   int n_errors = 0;
   int n_tests = 0;
   // Design and host model
   scs_sequencer scs_sequencer_inst (.clk, .rst, .conversion_start_n, .coding_select,
      .warp_select, .impulse_select, .comparator_high, .over_range, .under_range,
      .sample_switch_closed, .array_ground_switch(), .dummy_ground_switch(),
      .array_to_reference_ground(), .dac_trial, .analog_power_up, .busy, .output_code,
      .first_result_stale, .active_mode);
   scs_host scs_host_inst (.clk, .start, .sample, .dac_trial, .conversion_start_n,
      .comparator_high);
   initial forever #4 clk = ~clk;
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         $display("ERROR %s expected %h seen %h", name, exp, seen);
         n_errors++;
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // One conversion; twice adds a stray start mid-way, which must be ignored
   task automatic convert(input logic [15:0] val, input logic sel, ovr, und, twice);
      int cyc;
      @(posedge clk);
      sample <= val;
      coding_select <= sel;
      over_range <= ovr;
      under_range <= und;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      for (cyc = 0; cyc < 20 && busy !== 1'b1; cyc++)
         @(negedge clk);
      check("busy_rise", {15'h0, busy}, 16'h0001);
      if (busy !== 1'b1)
         summarize();
      for (cyc = 0; busy === 1'b1 && cyc < 40; cyc++)
      begin
         @(posedge clk);
         start <= twice && cyc == 3;
         @(negedge clk);
      end
      check("busy_cycles", 16'(cyc), 16'h0012);
      if (busy === 1'b1)
         summarize();
      check("code", output_code, ovr ? (sel ? 16'hFFFF : 16'h7FFF) : und ?
         (sel ? 16'h0000 : 16'h8000) : sel ? val : val ^ 16'h8000);
      repeat (8) @(negedge clk);
      check("idle_busy", {15'h0, busy}, 16'h0000);
   endtask
   // Warp mode flags the first result after power-up, not the next one
   task automatic t_stale();
      @(posedge clk);
      warp_select <= 1'b1;
      repeat (8) @(negedge clk);
      check("stale_idle", {15'h0, first_result_stale}, 16'h0001);
      convert(16'h3C3C, 1'b1, 1'b0, 1'b0, 1'b0);
      check("stale_first", {15'h0, first_result_stale}, 16'h0001);
      convert(16'h3C3C, 1'b1, 1'b0, 1'b0, 1'b0);
      check("stale_next", {15'h0, first_result_stale}, 16'h0000);
      @(posedge clk);
      warp_select <= 1'b0;
      $display("test stale done");
   endtask
   // Boundary and mixed codes in both codings, each result from its own sample
   task automatic t_codes();
      logic [15:0] vals [6] = '{16'h0000, 16'h8000, 16'hFFFF, 16'h0001, 16'h7FFF, 16'hA5C3};
      foreach (vals[i])
         for (int s = 0; s < 2; s++)
            convert(vals[i], s[0], 1'b0, 1'b0, 1'b0);
      convert(16'h5A5A, 1'b1, 1'b0, 1'b0, 1'b1);
      $display("test codes done");
   endtask
   // Over, under and both flags; overrange wins
   task automatic t_range();
      for (int k = 1; k < 4; k++)
         for (int s = 0; s < 2; s++)
            convert(16'h1234, s[0], k[0], k[1], 1'b0);
      $display("test range done");
   endtask
   // Every select pair, one conversion in each mode
   task automatic t_modes();
      scs_mode_t exp [4] = '{SCS_MODE_NORMAL, SCS_MODE_WARP, SCS_MODE_IMPULSE, SCS_MODE_WARP};
      for (int m = 0; m < 4; m++)
      begin
         @(posedge clk);
         warp_select <= m[0];
         impulse_select <= m[1];
         repeat (8) @(negedge clk);
         check("mode", {14'h0, active_mode}, {14'h0, exp[m]});
         check("power_up", {15'h0, analog_power_up}, {15'h0, exp[m] != SCS_MODE_IMPULSE});
         convert(16'hC001, 1'b1, 1'b0, 1'b0, 1'b0);
      end
      $display("test modes done");
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check("reset_code", output_code, 16'h0000);
      check("reset_switch", {15'h0, sample_switch_closed}, 16'h0001);
      t_stale();
      t_codes();
      t_range();
      t_modes();
      summarize();
   end
endmodule // scs_sequencer_tb

// ==== testbench/scs_sva.sv ====
// Port assertions of the conversion sequencer
module scs_sva
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Watched ports
   input wire logic conversion_start_n,
   input wire logic coding_select,
   input wire logic over_range,
   input wire logic under_range,
   input wire logic sample_switch_closed,
   input wire logic array_ground_switch,
   input wire logic dummy_ground_switch,
   input wire logic array_to_reference_ground,
   input wire logic [scs_pkg::CODE_W-1:0] dac_trial,
   input wire logic analog_power_up,
   input wire logic busy,
   input wire logic [scs_pkg::CODE_W-1:0] output_code
);
   timeunit 1ns;
   timeprecision 1ps;
   import scs_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Switches open before the array is grounded
   sequence s_open_ground;
      !sample_switch_closed && !array_ground_switch && !array_to_reference_ground
         ##1 array_to_reference_ground;
   endsequence
   sequence s_busy_18;
      busy [*8] ##1 busy [*8] ##1 busy ##1 busy ##1 !busy;
   endsequence
   a_start_busy: assert property ($fell(conversion_start_n) && !busy |-> ##[3:8] $rose(busy))
      else $error("busy late after start");
   a_switch_order: assert property ($rose(busy) |-> s_open_ground)
      else $error("switch order wrong");
   a_switch_open: assert property (busy |-> !sample_switch_closed && !array_ground_switch
      && !dummy_ground_switch)
      else $error("switch closed while busy");
   a_first_trial: assert property ($rose(busy) |-> ##2 dac_trial == MSB_ONLY)
      else $error("first trial not msb");
   a_busy_length: assert property ($rose(busy) |-> s_busy_18)
      else $error("busy length wrong");
   a_code_hold: assert property (!$fell(busy) |-> $stable(output_code))
      else $error("code moved during conversion");
   a_over_code: assert property ($rose(busy) ##1 over_range |-> ##17
      output_code == (coding_select ? CODE_MAX_SB : CODE_MAX_SB ^ MSB_ONLY))
      else $error("overrange code wrong");
   a_under_code: assert property ($rose(busy) ##1 under_range && !over_range |-> ##17
      output_code == (coding_select ? CODE_MIN_SB : MSB_ONLY))
      else $error("underrange code wrong");
   a_power_busy: assert property (busy |-> analog_power_up)
      else $error("powered down while busy");
endmodule // scs_sva
bind scs_sequencer scs_sva scs_sva_inst (.clk, .rst, .conversion_start_n, .coding_select,
   .over_range, .under_range, .sample_switch_closed, .array_ground_switch,
   .dummy_ground_switch, .array_to_reference_ground, .dac_trial, .analog_power_up, .busy,
   .output_code);
